/* File: sfes_defines.vh */
`ifndef SFES_DEFINES_VH
`define SFES_DEFINES_VH
// Sector geometry: four sectors of 32 KiB, 17-bit byte address
`define SFES_ADDR_W       17
`define SFES_SECT_MSB     16
`define SFES_SECT_LSB     15
`define SFES_OFFS_W       15
`define SFES_OFFS_LAST    15'h7FFF
`define SFES_NUM_SECT     4
// Erased byte value
`define SFES_ERASED_BYTE  8'hFF
// Protection levels from the two block-protect bits
`define SFES_PROT_NONE    2'h0
`define SFES_PROT_QUARTER 2'h1
`define SFES_PROT_HALF    2'h2
`define SFES_PROT_ALL     2'h3
// Lock masks, one bit per sector, bit 3 is the top sector
`define SFES_MASK_NONE    4'h0
`define SFES_MASK_QUARTER 4'h8
`define SFES_MASK_HALF    4'hC
`define SFES_MASK_ALL     4'hF
// Status bit position of the busy flag
`define SFES_BUSY_BIT     0
// Erase times in milliseconds and the clock rate in kHz
`define SFES_CHIP_MS      3500
`define SFES_SECT_MS      1000
`define SFES_CLK_KHZ      50000
`endif

/* File: sfes_lock_decode.v */
`timescale 1ns/100ps
`include "sfes_defines.vh"
////////////////////////////////////////////////////////////////////////////
// Protection level to per-sector lock mask, purely combinational
module sfes_lock_decode (
  blockProtectHi,
  blockProtectLo,
  lockMask
);
  input  wire       blockProtectHi; // Upper protect bit
  input  wire       blockProtectLo; // Lower protect bit
  output reg  [3:0] lockMask;       // One bit per sector, set = locked

  // Top quarter, top half or whole array
  always @* begin
    case ({blockProtectHi, blockProtectLo})
      `SFES_PROT_NONE:    lockMask = `SFES_MASK_NONE;    // [R9]
      `SFES_PROT_QUARTER: lockMask = `SFES_MASK_QUARTER; // [R9]
      `SFES_PROT_HALF:    lockMask = `SFES_MASK_HALF;    // [R9]
      default:            lockMask = `SFES_MASK_ALL;     // [R9]
    endcase
  end
endmodule // sfes_lock_decode

/* File: sfes_erase_sequencer.v */
`timescale 1ns/100ps
`include "sfes_defines.vh"
// Summary of operation
// R1: Chip erase clears unlocked sectors, skips locked
// R2: Host sets write latch before erase
// R3: Erase runs self-timed without host help
// R4: Chip erase busy about 3.5 seconds
// R5: Only status read answered while busy
// R6: Chip erase end clears write latch
// R7: Sector erase end clears write latch
// R8: Status bit 0 shows busy
// R9: Protect bits lock none, quarter, half, all
// R10: Sector erase clears addressed unlocked sector
// R11: Erased bytes read back all ones
module sfes_erase_sequencer #(
  parameter CHIP_CYCLES = (`SFES_CHIP_MS * `SFES_CLK_KHZ), // Chip erase time
  parameter SECT_CYCLES = (`SFES_SECT_MS * `SFES_CLK_KHZ), // Sector erase time
  parameter CNT_W       = 28                               // Timer width
) (
  sys_clk,
  sys_rst,
  chipEraseReq,
  sectEraseReq,
  sectEraseAddr,
  writeLatchSet,
  writeLatchClr,
  blockProtectHi,
  blockProtectLo,
  cmdValid,
  cmdIsStatusRead,
  cmdAccept,
  writeLatch,
  statusBusy,
  memWe,
  memAddr,
  memData,
  eraseDone
);
  input  wire                      sys_clk;         // System clock
  input  wire                      sys_rst;         // Sync reset, high
  input  wire                      chipEraseReq;    // Chip erase pulse
  input  wire                      sectEraseReq;    // Sector erase pulse
  input  wire [`SFES_ADDR_W-1:0]   sectEraseAddr;   // Any addr in sector
  input  wire                      writeLatchSet;   // Write-enable command
  input  wire                      writeLatchClr;   // Write-disable command
  input  wire                      blockProtectHi;  // Protect level hi
  input  wire                      blockProtectLo;  // Protect level lo
  input  wire                      cmdValid;        // Decoded command
  input  wire                      cmdIsStatusRead; // Command is status read
  output wire                      cmdAccept;       // Command passed on
  output reg                       writeLatch;      // Write-enable latch
  output wire [7:0]                statusBusy;      // Busy part of status
  output reg                       memWe;           // Array write strobe
  output reg  [`SFES_ADDR_W-1:0]   memAddr;         // Array byte address
  output reg  [7:0]                memData;         // Array write data
  output reg                       eraseDone;       // End of erase pulse

  // States
  localparam ST_IDLE = 2'h0;
  localparam ST_WIPE = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg  [1:0]             state_r;    // Sequencer state
  reg  [1:0]             state_nxt;
  reg  [3:0]             todo_r;     // Sectors still to clear
  reg  [3:0]             todo_nxt;
  reg  [1:0]             sect_r;     // Sector being cleared
  reg  [1:0]             sect_nxt;
  reg  [`SFES_OFFS_W-1:0] offs_r;    // Byte offset in sector
  reg  [`SFES_OFFS_W-1:0] offs_nxt;
  reg  [CNT_W-1:0]       timer_r;    // Remaining busy cycles
  reg  [CNT_W-1:0]       timer_nxt;
  wire [3:0]             lockMask;   // Locked sectors
  wire                   busy;       // Erase running
  wire                   startChip;  // Accepted chip erase
  wire                   startSect;  // Accepted sector erase
  wire [1:0]             reqSect;    // Addressed sector

  ////////////////////////////////////////////////////////////////////////
  // Lowest pending sector index
  function [1:0] firstSect;
    input [3:0] m;
    begin
      if (m[0])      firstSect = 2'h0;
      else if (m[1]) firstSect = 2'h1;
      else if (m[2]) firstSect = 2'h2;
      else           firstSect = 2'h3;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  sfes_lock_decode uLock (
    .blockProtectHi (blockProtectHi),
    .blockProtectLo (blockProtectLo),
    .lockMask       (lockMask)
  );

  assign busy      = (state_r != ST_IDLE);
  assign reqSect   = sectEraseAddr[`SFES_SECT_MSB:`SFES_SECT_LSB];
  // Write latch must already be set by an earlier frame [R2]
  assign startChip = !busy && chipEraseReq && writeLatch;
  assign startSect = !busy && !chipEraseReq && sectEraseReq && writeLatch;
  // While busy only the status read reaches the decoder [R5]
  assign cmdAccept = cmdValid && (!busy || cmdIsStatusRead);
  // Bit 0 of status is busy; other bits belong to the status register
  assign statusBusy = {7'h00, busy}; // [R8]

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic: wipe the target sectors, then wait out the time
  always @* begin
    state_nxt = state_r;
    todo_nxt  = todo_r;
    sect_nxt  = sect_r;
    offs_nxt  = offs_r;
    timer_nxt = timer_r;
    case (state_r)
      ST_IDLE: begin
        if (startChip) begin
          // Only sectors not locked out are queued [R1]
          todo_nxt  = ~lockMask;                 // [R1]
          sect_nxt  = firstSect(~lockMask);
          offs_nxt  = {`SFES_OFFS_W{1'b0}};
          timer_nxt = CHIP_CYCLES[CNT_W-1:0];    // [R4]
          state_nxt = ST_WIPE;                   // [R3]
        end else if (startSect) begin
          // A locked sector still runs the cycle but is never touched
          todo_nxt  = lockMask[reqSect] ? 4'h0 : (4'h1 << reqSect); // [R10]
          sect_nxt  = reqSect;
          offs_nxt  = {`SFES_OFFS_W{1'b0}};
          timer_nxt = SECT_CYCLES[CNT_W-1:0];
          state_nxt = ST_WIPE;                   // [R3]
        end
      end
      ST_WIPE: begin
        if (timer_r != {CNT_W{1'b0}})
          timer_nxt = timer_r - 1'b1;
        if (todo_r == 4'h0) begin
          state_nxt = ST_WAIT;
        end else if (offs_r == `SFES_OFFS_LAST) begin
          // Sector finished, move on to the next pending one
          offs_nxt         = {`SFES_OFFS_W{1'b0}};
          todo_nxt         = todo_r & ~(4'h1 << sect_r);
          sect_nxt         = firstSect(todo_r & ~(4'h1 << sect_r));
        end else begin
          offs_nxt = offs_r + 1'b1;
        end
      end
      ST_WAIT: begin
        // Self-timed; no host activity needed to finish [R3]
        if (timer_r <= {{(CNT_W-1){1'b0}}, 1'b1})
          state_nxt = ST_IDLE;
        else
          timer_nxt = timer_r - 1'b1;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      todo_r  <= 4'h0;
      sect_r  <= 2'h0;
      offs_r  <= {`SFES_OFFS_W{1'b0}};
      timer_r <= {CNT_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      todo_r  <= todo_nxt;
      sect_r  <= sect_nxt;
      offs_r  <= offs_nxt;
      timer_r <= timer_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array write port: one erased byte per cycle
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      memWe   <= 1'b0;
      memAddr <= {`SFES_ADDR_W{1'b0}};
      memData <= `SFES_ERASED_BYTE;
    end else begin
      memWe   <= (state_r == ST_WIPE) && (todo_r != 4'h0); // [R1] [R10]
      memAddr <= {sect_r, offs_r};
      memData <= `SFES_ERASED_BYTE;                        // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write-enable latch and end-of-erase pulse
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      writeLatch <= 1'b0;
      eraseDone  <= 1'b0;
    end else begin
      eraseDone <= 1'b0;
      if (busy && state_nxt == ST_IDLE) begin
        // Erase end returns to write-disabled [R6] [R7]
        writeLatch <= 1'b0;
        eraseDone  <= 1'b1;
      end else if (!busy && (startChip || startSect)) begin
        writeLatch <= writeLatch;
      end else if (!busy && writeLatchClr) begin
        writeLatch <= 1'b0;
      end else if (!busy && writeLatchSet) begin
        writeLatch <= 1'b1;
      end
    end
  end
endmodule // sfes_erase_sequencer

/* File: sfes_erase_checker_properties.sv */
`timescale 1ns/100ps
`include "sfes_defines.vh"
////////////////////////////////////////
// Port-level watch on the erase sequencer
module sfes_erase_checker (
  input wire logic                    sys_clk,
  input wire logic                    sys_rst,
  input wire logic                    chipEraseReq,
  input wire logic                    writeLatch,
  input wire logic                    blockProtectHi,
  input wire logic                    blockProtectLo,
  input wire logic                    cmdValid,
  input wire logic                    cmdIsStatusRead,
  input wire logic                    cmdAccept,
  input wire logic [7:0]              statusBusy,
  input wire logic                    memWe,
  input wire logic [`SFES_ADDR_W-1:0] memAddr,
  input wire logic [7:0]              memData,
  input wire logic                    eraseDone
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire [1:0] lvl = {blockProtectHi, blockProtectLo}; // Protect level
  // Locked sectors are always the top ones
  wire lockHit = (lvl == 2'h3) || (lvl == 2'h2 && memAddr[16]) ||
                 (lvl == 2'h1 && memAddr[16:15] == 2'h3);
  wire takeChip = chipEraseReq && writeLatch && !statusBusy[0];
  chk_erase_start: assert property (takeChip |=> statusBusy[0])
    else $error("erase did not start");
  chk_first_write: assert property (takeChip && lvl != 2'h3 |->
    ##2 memWe) else $error("first write late");
  chk_status_pad: assert property (statusBusy[7:1] == 7'h00)
    else $error("status padding set");
  chk_refuse_busy: assert property (statusBusy[0] && cmdValid &&
    !cmdIsStatusRead |-> !cmdAccept) else $error("command passed busy");
  chk_status_pass: assert property (cmdValid && cmdIsStatusRead |->
    cmdAccept) else $error("status read refused");
  chk_latch_clear: assert property ($fell(statusBusy[0]) |->
    eraseDone && !writeLatch) else $error("latch left set");
  chk_erased_ones: assert property (memWe |->
    memData == `SFES_ERASED_BYTE) else $error("erase data wrong");
  chk_skip_locked: assert property (memWe |-> !lockHit)
    else $error("locked sector written");
  chk_addr_step: assert property (memWe && $past(memWe) |->
    memAddr == $past(memAddr) + 1'b1) else $error("address skipped");
  chk_done_pulse: assert property (eraseDone |=> !eraseDone)
    else $error("done too long");
  chk_write_busy: assert property (memWe |-> statusBusy[0])
    else $error("write while idle");
endmodule // sfes_erase_checker
bind sfes_erase_sequencer sfes_erase_checker i_chk (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .chipEraseReq(chipEraseReq), .writeLatch(writeLatch),
  .blockProtectHi(blockProtectHi), .blockProtectLo(blockProtectLo),
  .cmdValid(cmdValid), .cmdIsStatusRead(cmdIsStatusRead),
  .cmdAccept(cmdAccept), .statusBusy(statusBusy), .memWe(memWe),
  .memAddr(memAddr), .memData(memData), .eraseDone(eraseDone));

/* File: sfes_host_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////
// Host side: decoded commands as strobes
module sfes_host_model (
  input wire logic     sys_clk,
  input wire logic     cmdAccept,
  output logic         chipEraseReq,
  output logic         sectEraseReq,
  output logic [16:0]  sectEraseAddr,
  output logic         writeLatchSet,
  output logic         writeLatchClr,
  output logic         blockProtectHi,
  output logic         blockProtectLo,
  output logic         cmdValid,
  output logic         cmdIsStatusRead
);
  logic [5:0]  vec_r = 6'h00;       // Strobes, one frame each
  logic [1:0]  prot_r = 2'h0;       // Protect level, held steady
  logic [16:0] addr_r = 17'h0_0000; // Sector erase address
  assign {chipEraseReq, sectEraseReq, writeLatchSet, writeLatchClr,
          cmdValid, cmdIsStatusRead} = vec_r;
  assign {blockProtectHi, blockProtectLo} = prot_r;
  assign sectEraseAddr = addr_r;
  // One cycle strobe; answer taken late, once settled
  task automatic pulse(input logic [5:0] v, output logic acc);
    @(posedge sys_clk);
    #1 vec_r = v;
    #15 acc = cmdAccept;
    @(posedge sys_clk);
    #1 vec_r = 6'h00;
  endtask
  // Latch set in its own frame before the erase
  task automatic erase(input logic [5:0] v);
    logic a;
    pulse(6'h0A, a);
    pulse(v, a);
  endtask
endmodule // sfes_host_model

/* File: serial_flash_erase_sequencer_bench.sv */
`timescale 1ns/100ps
////////////////////////////////////////
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch %0t %s", $time, m); end end
module serial_flash_erase_sequencer_bench;
  localparam CHIP = 65600; // Short erase times, above wipe floor
  localparam SECT = 200;   // Open sector runs past this on its wipe
  localparam [5:0] C_CHIP = 6'h22, C_SECT = 6'h12, C_CLR = 6'h06;
  localparam [5:0] C_STAT = 6'h03;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire chipEraseReq, sectEraseReq, writeLatchSet, writeLatchClr, cmdValid;
  wire blockProtectHi, blockProtectLo, cmdIsStatusRead, cmdAccept;
  wire writeLatch, memWe, eraseDone;
  wire [7:0] statusBusy, memData;
  wire [16:0] sectEraseAddr, memAddr;
  int error_cnt = 0, compares = 0, cyc = 0, wrCnt, busyCnt, doneCnt;
  logic [16:0] firstAddr, lastAddr;
  logic acc;
  always #10 sys_clk = ~sys_clk;
  sfes_host_model i_host (.sys_clk(sys_clk), .cmdAccept(cmdAccept),
    .chipEraseReq(chipEraseReq), .sectEraseReq(sectEraseReq),
    .sectEraseAddr(sectEraseAddr), .writeLatchSet(writeLatchSet),
    .writeLatchClr(writeLatchClr), .blockProtectHi(blockProtectHi),
    .blockProtectLo(blockProtectLo), .cmdValid(cmdValid),
    .cmdIsStatusRead(cmdIsStatusRead));
  sfes_erase_sequencer #(.CHIP_CYCLES(CHIP), .SECT_CYCLES(SECT)) i_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .chipEraseReq(chipEraseReq),
    .sectEraseReq(sectEraseReq), .sectEraseAddr(sectEraseAddr),
    .writeLatchSet(writeLatchSet), .writeLatchClr(writeLatchClr),
    .blockProtectHi(blockProtectHi), .blockProtectLo(blockProtectLo),
    .cmdValid(cmdValid), .cmdIsStatusRead(cmdIsStatusRead),
    .cmdAccept(cmdAccept), .writeLatch(writeLatch), .statusBusy(statusBusy),
    .memWe(memWe), .memAddr(memAddr), .memData(memData),
    .eraseDone(eraseDone));
  // Tally writes, busy cycles and done pulses
  always @(posedge sys_clk) begin
    if (memWe === 1'b1) begin
      if (wrCnt == 0) firstAddr = memAddr;
      lastAddr = memAddr;
      wrCnt++;
    end
    if (statusBusy[0] === 1'b1) busyCnt++;
    if (eraseDone === 1'b1) doneCnt++;
  end
  // Hang guard, just past all erases
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 99500) begin
      error_cnt++;
      $display("mismatch %0t timeout", $time);
      end_sim();
    end
  end
  task clear_counts();
    wrCnt = 0;
    busyCnt = 0;
    doneCnt = 0;
  endtask
  // Cycle ceiling bounds this wait
  // Busy is looked at off the edge; one more edge lets the tally
  // see the done pulse
  task wait_idle();
    do begin
      @(posedge sys_clk);
      #1;
    end while (statusBusy[0] !== 1'b0);
    @(posedge sys_clk);
    #1;
  endtask
  task test_refuse();
    i_host.pulse(C_CHIP, acc);
    repeat (3) @(posedge sys_clk);
    #1 `CHK(statusBusy, 8'h00, "erase ran without latch")
    `CHK(writeLatch, 1'b0, "latch set by erase")
    $display("test refuse done");
  endtask
  task test_chip();
    i_host.prot_r = 2'h2;
    clear_counts();
    i_host.erase(C_CHIP);
    `CHK(statusBusy, 8'h01, "chip not busy")
    i_host.pulse(C_CLR, acc);
    `CHK(acc, 1'b0, "clear passed while busy")
    `CHK(writeLatch, 1'b1, "latch cleared while busy")
    i_host.pulse(C_STAT, acc);
    `CHK(acc, 1'b1, "status read refused")
    i_host.pulse(C_SECT, acc);
    wait_idle();
    `CHK(wrCnt, 65536, "chip write count")
    `CHK(firstAddr, 17'h0_0000, "first write")
    `CHK(lastAddr, 17'h0_FFFF, "last write")
    `CHK(busyCnt >= CHIP - 1 && busyCnt <= CHIP + 1, 1'b1, "chip time")
    `CHK(writeLatch, 1'b0, "latch kept after chip")
    `CHK(doneCnt, 1, "done pulse count")
    $display("test chip done");
  endtask
  task test_sect();
    i_host.prot_r = 2'h1;
    i_host.addr_r = 17'h1_9ABC;
    clear_counts();
    i_host.erase(C_SECT);
    wait_idle();
    `CHK(wrCnt, 0, "locked sector written")
    `CHK(busyCnt >= SECT - 1 && busyCnt <= SECT + 1, 1'b1, "sect time")
    `CHK(writeLatch, 1'b0, "latch kept after sector")
    `CHK(statusBusy, 8'h00, "busy after sector")
    $display("test sector done");
  endtask
  task test_sect_open();
    i_host.addr_r = 17'h0_9ABC;
    clear_counts();
    i_host.erase(C_SECT);
    wait_idle();
    `CHK(wrCnt, 32768, "open sector count")
    `CHK(firstAddr, 17'h0_8000, "open sector first")
    `CHK(lastAddr, 17'h0_FFFF, "open sector last")
    `CHK(writeLatch, 1'b0, "latch kept after open sector")
    `CHK(doneCnt, 1, "open sector done count")
    $display("test open sector done");
  endtask
  task end_sim();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    test_refuse();
    test_chip();
    test_sect();
    test_sect_open();
    end_sim();
  end
endmodule // serial_flash_erase_sequencer_bench
